// [core/overcurrent_setting_logic.v]
`timescale 1ns/100ps
`include "oc_regs.vh"
module overcurrent_setting_logic #(
   parameter TICK_CYCLES = `CLK_HZ / 1000 * `TICK_MS
) (
   input wire ref_clk,
   input wire srst,
   input wire meas_valid,
   input wire [11:0] cur_a,
   input wire [11:0] cur_b,
   input wire [11:0] cur_c,
   input wire [11:0] cur_residual,
   input wire [11:0] cur_core,
   input wire gnd_core_balance,
   input wire [3:0] ph_pickup_code,
   input wire [3:0] ph_curve_code,
   input wire [3:0] ph_mult,
   input wire [1:0] ph_shift,
   input wire [3:0] ph_inst_code,
   input wire [3:0] gnd_pickup_code,
   input wire [3:0] gnd_curve_code,
   input wire [3:0] gnd_mult,
   input wire [1:0] gnd_shift,
   input wire [3:0] gnd_inst_code,
   output reg ph_pickup_flash_ff,
   output reg gnd_pickup_flash_ff,
   output reg [2:0] ph_toc_trip_ff,
   output reg [2:0] ph_ioc_trip_ff,
   output reg gnd_toc_trip_ff,
   output reg gnd_ioc_trip_ff,
   output reg trip_ff
);
   // pickup percent of sensing rating from band and dial code
   function [11:0] pick_pct;
      input gnd;
      input hi;
      input [3:0] code;
      reg [3:0] c;
      begin
         c = (code > `CODE_TOP) ? `CODE_TOP : code;
         if (gnd && hi)
            pick_pct = 12'h037 + {8'h00, c} * 12'h005;
         else if (gnd)
            pick_pct = 12'h00A + {8'h00, c} * 12'h005;
         else if (!hi)
            pick_pct = 12'h00A + {8'h00, c} * 12'h00A;
         else begin
            case (c)
               4'h1: pick_pct = 12'h06E;
               4'h2: pick_pct = 12'h078;
               4'h3: pick_pct = 12'h087;
               4'h4: pick_pct = 12'h091;
               4'h5: pick_pct = 12'h0A0;
               4'h6: pick_pct = 12'h0AA;
               4'h7: pick_pct = 12'h0B4;
               4'h8: pick_pct = 12'h0C8;
               default: pick_pct = 12'h0DC;
            endcase
         end
      end
   endfunction

   // instantaneous threshold in percent, zero means off
   function [11:0] inst_pct;
      input gnd;
      input [3:0] code;
      begin
         case (code)
            `CODE_OFF: inst_pct = 12'h000;
            4'h1: inst_pct = gnd ? 12'h00A : 12'h0C8;
            4'h2: inst_pct = gnd ? 12'h014 : 12'h12C;
            4'h3: inst_pct = gnd ? 12'h032 : 12'h190;
            4'h4: inst_pct = gnd ? 12'h064 : 12'h1F4;
            4'h5: inst_pct = gnd ? 12'h0C8 : 12'h258;
            4'h6: inst_pct = gnd ? 12'h190 : 12'h320;
            4'h7: inst_pct = 12'h320 + (gnd ? 12'h000 : 12'h0C8);
            4'h8: inst_pct = 12'h4B0;
            default: inst_pct = 12'h640;
         endcase
      end
   endfunction

   // curve code: bits 3..1 shape, bit 0 high band
   function [2:0] shape_of;
      input [3:0] code;
      begin
         case (code[3:1])
            `SHAPE_DEF: shape_of = `SHAPE_DEF;
            `SHAPE_MOD: shape_of = `SHAPE_MOD;
            `SHAPE_NRM: shape_of = `SHAPE_NRM;
            `SHAPE_VRY: shape_of = `SHAPE_VRY;
            default: shape_of = `SHAPE_EXT;
         endcase
      end
   endfunction

   // multiplier dial, out-of-range codes clamped
   function [3:0] mult_clamp;
      input [3:0] m;
      begin
         if (m < `MULT_MIN)
            mult_clamp = `MULT_MIN;
         else if (m > `MULT_MAX)
            mult_clamp = `MULT_MAX;
         else
            mult_clamp = m;
      end
   endfunction

   // strict compare, zero threshold means off
   function over_inst;
      input [11:0] cur;
      input [11:0] thr;
      begin
         over_inst = (thr != 12'h000) && (cur > thr);
      end
   endfunction

   // dial settings: two-stage capture, second stage is the live setting
   wire [`SET_W-1:0] set_in = {gnd_core_balance,
                               ph_pickup_code, ph_curve_code, ph_mult, ph_shift, ph_inst_code,
                               gnd_pickup_code, gnd_curve_code, gnd_mult, gnd_shift, gnd_inst_code};
   reg [`SET_W-1:0] set_s1_ff;
   reg [`SET_W-1:0] set_ff;

   always @(posedge ref_clk) begin
      if (srst) begin
         set_s1_ff <= {`SET_W{1'b0}};
         set_ff <= {`SET_W{1'b0}};
      end else begin
         set_s1_ff <= set_in;
         set_ff <= set_s1_ff;
      end
   end

   // live setting fields
   wire core_sel = set_ff[36];
   wire [3:0] s_ph_pick = set_ff[35:32];
   wire [3:0] s_ph_curve = set_ff[31:28];
   wire [3:0] s_ph_mult = set_ff[27:24];
   wire [1:0] s_ph_shift = set_ff[23:22];
   wire [3:0] s_ph_inst = set_ff[21:18];
   wire [3:0] s_gnd_pick = set_ff[17:14];
   wire [3:0] s_gnd_curve = set_ff[13:10];
   wire [3:0] s_gnd_mult = set_ff[9:6];
   wire [1:0] s_gnd_shift = set_ff[5:4];
   wire [3:0] s_gnd_inst = set_ff[3:0];

   // measured magnitudes, held between samples
   reg [11:0] ia_ff;
   reg [11:0] ib_ff;
   reg [11:0] ic_ff;
   reg [11:0] ires_ff;
   reg [11:0] icore_ff;

   always @(posedge ref_clk) begin
      if (srst) begin
         ia_ff <= 12'h000;
         ib_ff <= 12'h000;
         ic_ff <= 12'h000;
         ires_ff <= 12'h000;
         icore_ff <= 12'h000;
      end else if (meas_valid) begin
         ia_ff <= cur_a;
         ib_ff <= cur_b;
         ic_ff <= cur_c;
         ires_ff <= cur_residual;
         icore_ff <= cur_core;
      end
   end

   // ground source select
   wire [11:0] ignd = core_sel ? icore_ff : ires_ff;

   // setting decode
   wire ph_en = (s_ph_pick != `CODE_OFF);
   wire gnd_en = (s_gnd_pick != `CODE_OFF);
   wire [2:0] ph_shape = shape_of(s_ph_curve);
   wire [2:0] gnd_shape = shape_of(s_gnd_curve);
   // band select from curve code bit 0
   wire ph_high_pickup_band = s_ph_curve[0];
   wire gnd_high_pickup_band = s_gnd_curve[0];
   wire [11:0] ph_pick = pick_pct(1'b0, ph_high_pickup_band, s_ph_pick);
   wire [11:0] gnd_pick = pick_pct(1'b1, gnd_high_pickup_band, s_gnd_pick);
   wire [3:0] ph_m = mult_clamp(s_ph_mult);
   wire [3:0] gnd_m = mult_clamp(s_gnd_mult);
   wire [11:0] ph_thr = inst_pct(1'b0, s_ph_inst);
   wire [11:0] gnd_thr = inst_pct(1'b1, s_gnd_inst);

   // millisecond tick and pickup flash rate
   reg [15:0] tick_cnt_ff;
   reg tick_ff;
   reg [7:0] flash_cnt_ff;
   reg flash_ff;

   always @(posedge ref_clk) begin
      if (srst) begin
         tick_cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= 1'b0;
         if (tick_cnt_ff >= TICK_CYCLES[15:0] - 16'h0001) begin
            tick_cnt_ff <= 16'h0000;
            tick_ff <= 1'b1;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 16'h0001;
         end
      end
   end

   // flash phase toggles every flash period of ticks
   always @(posedge ref_clk) begin
      if (srst) begin
         flash_cnt_ff <= 8'h00;
         flash_ff <= 1'b0;
      end else if (tick_ff) begin
         if (flash_cnt_ff >= `FLASH_TICKS - 8'h01) begin
            flash_cnt_ff <= 8'h00;
            flash_ff <= ~flash_ff;
         end else begin
            flash_cnt_ff <= flash_cnt_ff + 8'h01;
         end
      end
   end

   // timed elements, one per phase and one for ground
   wire [2:0] ph_above;
   wire [2:0] ph_toc;
   wire gnd_above;
   wire gnd_toc;
   // phase currents packed a, b, c
   wire [35:0] ph_cur = {ic_ff, ib_ff, ia_ff};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : phase_el
         toc_element u_toc (
            .ref_clk(ref_clk),
            .srst(srst),
            .tick(tick_ff),
            .enable(ph_en),
            .cur(ph_cur[g*12 +: 12]),
            .pickup(ph_pick),
            .shape(ph_shape),
            .mult(ph_m),
            .shift(s_ph_shift),
            .above_ff(ph_above[g]),
            .trip_ff(ph_toc[g])
         );
      end
   endgenerate

   toc_element u_gnd_toc (
      .ref_clk(ref_clk),
      .srst(srst),
      .tick(tick_ff),
      .enable(gnd_en),
      .cur(ignd),
      .pickup(gnd_pick),
      .shape(gnd_shape),
      .mult(gnd_m),
      .shift(s_gnd_shift),
      .above_ff(gnd_above),
      .trip_ff(gnd_toc)
   );

   // instantaneous compare, no pickup dependence
   wire ioc_a = over_inst(ia_ff, ph_thr);
   wire ioc_b = over_inst(ib_ff, ph_thr);
   wire ioc_c = over_inst(ic_ff, ph_thr);
   wire [2:0] ph_ioc = {ioc_c, ioc_b, ioc_a};
   wire gnd_ioc = over_inst(ignd, gnd_thr);

   // pickup indications
   always @(posedge ref_clk) begin
      if (srst) begin
         ph_pickup_flash_ff <= 1'b0;
         gnd_pickup_flash_ff <= 1'b0;
      end else begin
         ph_pickup_flash_ff <= (|ph_above) && flash_ff;
         gnd_pickup_flash_ff <= gnd_above && flash_ff;
      end
   end

   // trip flags and combined trip, registered together one cycle after their sources
   always @(posedge ref_clk) begin
      if (srst) begin
         ph_toc_trip_ff <= 3'h0;
         ph_ioc_trip_ff <= 3'h0;
         gnd_toc_trip_ff <= 1'b0;
         gnd_ioc_trip_ff <= 1'b0;
         trip_ff <= 1'b0;
      end else begin
         ph_toc_trip_ff <= ph_toc;
         ph_ioc_trip_ff <= ph_ioc;
         gnd_toc_trip_ff <= gnd_toc;
         gnd_ioc_trip_ff <= gnd_ioc;
         trip_ff <= (|ph_toc) || (|ph_ioc) || gnd_toc || gnd_ioc;
      end
   end
endmodule

// [core/oc_regs.vh]
`ifndef OC_REGS_VH
`define OC_REGS_VH

`define CLK_HZ 50000000
`define TICK_MS 1
`define FLASH_TICKS 8'hFA
`define CUR_W 12
`define SHAPE_DEF 3'h0
`define SHAPE_MOD 3'h1
`define SHAPE_NRM 3'h2
`define SHAPE_VRY 3'h3
`define SHAPE_EXT 3'h4
`define SHIFT_NOM 2'h0
`define SHIFT_UP 2'h1
`define SHIFT_DOWN 2'h2
`define CODE_OFF 4'h0
`define CODE_TOP 4'h9
`define MULT_MIN 4'h1
`define MULT_MAX 4'hA
`define SET_W 37
`endif

// [core/toc_element.v]
`timescale 1ns/100ps
`include "oc_regs.vh"
module toc_element (
   input wire ref_clk,
   input wire srst,
   input wire tick,
   input wire enable,
   input wire [11:0] cur,
   input wire [11:0] pickup,
   input wire [2:0] shape,
   input wire [3:0] mult,
   input wire [1:0] shift,
   output reg above_ff,
   output reg trip_ff
);
   // base delay in ms per shape and over-pickup bucket
   function [11:0] base_ms;
      input [2:0] shp;
      input [1:0] bkt;
      begin
         case (shp)
            `SHAPE_DEF: base_ms = 12'h3E8;
            `SHAPE_MOD: base_ms = (bkt == 2'h0) ? 12'hBB8 : (bkt == 2'h1) ? 12'h5DC :
                                  (bkt == 2'h2) ? 12'h3E8 : 12'h2EE;
            `SHAPE_NRM: base_ms = (bkt == 2'h0) ? 12'hFA0 : (bkt == 2'h1) ? 12'h7D0 :
                                  (bkt == 2'h2) ? 12'h3E8 : 12'h1F4;
            `SHAPE_VRY: base_ms = (bkt == 2'h0) ? 12'hFA0 : (bkt == 2'h1) ? 12'h5DC :
                                  (bkt == 2'h2) ? 12'h258 : 12'h0FA;
            default: base_ms = (bkt == 2'h0) ? 12'hFA0 : (bkt == 2'h1) ? 12'h3E8 :
                               (bkt == 2'h2) ? 12'h190 : 12'h064;
         endcase
      end
   endfunction

   wire [14:0] cur_w = {3'h0, cur};
   wire [14:0] pick_w = {3'h0, pickup};
   wire [1:0] bucket = (cur_w >= {pick_w[11:0], 3'h0}) ? 2'h3 :
                       (cur_w >= {pick_w[12:0], 2'h0}) ? 2'h2 :
                       (cur_w >= {pick_w[13:0], 1'h0}) ? 2'h1 : 2'h0;
   wire above = enable && (cur > pickup);
   wire [15:0] nominal = base_ms(shape, bucket) * {12'h000, mult};
   reg [16:0] delay;
   reg [16:0] count_ff;
   reg [16:0] nxt_count;

   always @* begin
      case (shift)
         `SHIFT_UP: delay = {nominal, 1'b0};
         `SHIFT_DOWN: delay = {2'h0, nominal[15:1]};
         default: delay = {1'b0, nominal};
      endcase
   end

   always @* begin
      nxt_count = count_ff;
      if (!above)
         nxt_count = 17'h00000;
      else if (tick && (count_ff < delay))
         nxt_count = count_ff + 17'h00001;
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         count_ff <= 17'h00000;
         above_ff <= 1'b0;
         trip_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         above_ff <= above;
         trip_ff <= above && (count_ff >= delay);
      end
   end
endmodule

// [test/osl_checker.sv]
`timescale 1ns/100ps
module osl_checker (
   input wire ref_clk,
   input wire srst,
   input wire meas_valid,
   input wire [11:0] cur_a,
   input wire [3:0] ph_pickup_code,
   input wire [3:0] ph_inst_code,
   input wire [3:0] gnd_pickup_code,
   input wire [3:0] gnd_inst_code,
   input wire ph_pickup_flash_ff,
   input wire gnd_pickup_flash_ff,
   input wire [2:0] ph_toc_trip_ff,
   input wire [2:0] ph_ioc_trip_ff,
   input wire gnd_toc_trip_ff,
   input wire gnd_ioc_trip_ff,
   input wire trip_ff
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   wire any_trip = |{ph_toc_trip_ff, ph_ioc_trip_ff, gnd_toc_trip_ff, gnd_ioc_trip_ff};
   // phase a held at zero over two samples
   sequence s_a_zero;
      (meas_valid && cur_a == 12'h000) ##1 (!meas_valid || cur_a == 12'h000) ##1 (meas_valid && cur_a == 12'h000);
   endsequence
   sequence s_inst_live;
      (ph_inst_code != 4'h0) [*3] ##0 (meas_valid && cur_a > 12'h640);
   endsequence
   property p_rst;
      disable iff (1'b0) srst |=> !any_trip && !ph_pickup_flash_ff && !gnd_pickup_flash_ff;
   endproperty
   property p_or;
      trip_ff == any_trip;
   endproperty
   property p_ph_off;
      (ph_pickup_code == 4'h0) [*6] |-> ph_toc_trip_ff == 3'h0 && !ph_pickup_flash_ff;
   endproperty
   property p_gnd_off;
      (gnd_pickup_code == 4'h0) [*6] |-> !gnd_toc_trip_ff && !gnd_pickup_flash_ff;
   endproperty
   property p_ph_ioc_off;
      (ph_inst_code == 4'h0) [*5] |-> ph_ioc_trip_ff == 3'h0;
   endproperty
   property p_gnd_ioc_off;
      (gnd_inst_code == 4'h0) [*5] |-> !gnd_ioc_trip_ff;
   endproperty
   property p_ph_inst;
      s_inst_live |-> ##[1:2] ph_ioc_trip_ff[0];
   endproperty
   property p_drop;
      s_a_zero |-> ##2 !ph_toc_trip_ff[0] && !ph_ioc_trip_ff[0];
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not clear after reset");
   a_or: assert property (p_or) else $error("summary trip differs from flags");
   a_ph_off: assert property (p_ph_off) else $error("phase timed active while off");
   a_gnd_off: assert property (p_gnd_off) else $error("ground timed active while off");
   a_ph_ioc_off: assert property (p_ph_ioc_off) else $error("phase inst active while off");
   a_gnd_ioc_off: assert property (p_gnd_ioc_off) else $error("ground inst active while off");
   a_ph_inst: assert property (p_ph_inst) else $error("phase inst trip late");
   a_drop: assert property (p_drop) else $error("phase trip stays after current fell");
endmodule
bind overcurrent_setting_logic osl_checker osl_checker_i (.*);

// [test/ct_source.sv]
`timescale 1ns/100ps
module ct_source (
   input wire ref_clk,
   input wire srst,
   input wire [11:0] tgt_a,
   input wire [11:0] tgt_b,
   input wire [11:0] tgt_c,
   input wire [11:0] tgt_r,
   input wire [11:0] tgt_k,
   output reg meas_valid,
   output reg [11:0] cur_a,
   output reg [11:0] cur_b,
   output reg [11:0] cur_c,
   output reg [11:0] cur_residual,
   output reg [11:0] cur_core
);
   // sample every other cycle, stale lines inverted between samples
   always @(posedge ref_clk) begin
      meas_valid <= srst ? 1'b0 : ~meas_valid;
      if (meas_valid)
         {cur_a, cur_b, cur_c, cur_residual, cur_core} <= ~{cur_a, cur_b, cur_c, cur_residual, cur_core};
      else
         {cur_a, cur_b, cur_c, cur_residual, cur_core} <= {tgt_a, tgt_b, tgt_c, tgt_r, tgt_k};
   end
endmodule

// [test/tb_overcurrent_setting_logic.sv]
`timescale 1ns/100ps
module tb_overcurrent_setting_logic;
   localparam [71:0] PI = {8'h10, 8'h0C, 8'h0A, 8'h08, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02};
   localparam [71:0] GI = {8'hA0, 8'h78, 8'h50, 8'h28, 8'h14, 8'h0A, 8'h05, 8'h02, 8'h01};
   localparam [71:0] PH = {8'h2C, 8'h28, 8'h24, 8'h22, 8'h20, 8'h1D, 8'h1B, 8'h18, 8'h16};
   localparam [159:0] BASE = {32'h0208_1450, 32'h050C_1E50, 32'h0A14_2850, 32'h0F14_1E3C, 32'h1414_1414};
   reg ref_clk = 1'b0;
   reg srst = 1'b1;
   reg gnd_core_balance = 1'b0;
   reg seen;
   reg [3:0] ph_pickup_code = 4'h0, ph_curve_code = 4'h0, ph_mult = 4'h1, ph_inst_code = 4'h0;
   reg [3:0] gnd_pickup_code = 4'h0, gnd_curve_code = 4'h0, gnd_mult = 4'h1, gnd_inst_code = 4'h0;
   reg [1:0] ph_shift = 2'h0, gnd_shift = 2'h0;
   reg [11:0] tgt_a = 12'h000, tgt_b = 12'h000, tgt_c = 12'h000, tgt_r = 12'h000, tgt_k = 12'h000;
   wire meas_valid, ph_pickup_flash_ff, gnd_pickup_flash_ff, gnd_toc_trip_ff, gnd_ioc_trip_ff, trip_ff;
   wire [11:0] cur_a, cur_b, cur_c, cur_residual, cur_core;
   wire [2:0] ph_toc_trip_ff, ph_ioc_trip_ff;
   integer fails = 0, compares = 0, cyc = 0, i, k, c, g, hb, p, d, s, m, sh, n;
   always #10 ref_clk = ~ref_clk;
   ct_source ct_source_i (.*);
   overcurrent_setting_logic #(.TICK_CYCLES(2)) overcurrent_setting_logic_i (.*);
   function integer cl(input integer v);
      cl = 8 * (v > 9 ? 8 : v - 1);
   endfunction
   function integer thr(input integer gg, input integer v);
      thr = v == 0 ? 0 : gg ? GI[cl(v) +: 8] * 10 : PI[cl(v) +: 8] * 100;
   endfunction
   function integer pick(input integer gg, input integer h, input integer v);
      pick = gg ? (h ? 55 : 10) + 5 * (cl(v) / 8 + 1) : h ? PH[cl(v) +: 8] * 5 : 10 + 10 * (cl(v) / 8 + 1);
   endfunction
   task tk(input integer t);
      repeat (t) @(posedge ref_clk);
   endtask
   task chk(input [63:0] nm, input [31:0] sv, input [31:0] ev);
      begin
         compares = compares + 1;
         if (sv !== ev) begin
            fails = fails + 1;
            $display("ERROR %0s expected %0h seen %0h", nm, ev, sv);
         end
      end
   endtask
   task end_sim;
      begin
         $display("compares %0d fails %0d", compares, fails);
         if (fails == 0 && compares > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         fails = fails + 1;
         end_sim;
      end
   end
   initial begin
      i = $urandom(81);
      tk(4);
      srst <= 1'b0;
      tk(8);
      // instantaneous thresholds, ground source select
      for (i = 0; i < 32; i = i + 1) begin
         k = i % 2;
         c = i / 2;
         p = c ? thr(0, c) + k : 4095;
         d = c ? thr(1, c) + k : 4095;
         ph_inst_code <= c[3:0];
         gnd_inst_code <= c[3:0];
         gnd_core_balance <= c[0];
         tgt_a <= p[11:0];
         tgt_k <= c[0] ? d[11:0] : 12'hFFF;
         tgt_r <= c[0] ? 12'hFFF : d[11:0];
         tk(8);
         @(negedge ref_clk);
         chk("ph_ioc", ph_ioc_trip_ff, c && k);
         chk("gnd_ioc", gnd_ioc_trip_ff, c && k);
         chk("trip", trip_ff, c && k);
         @(posedge ref_clk);
      end
      ph_inst_code <= 4'h0;
      gnd_inst_code <= 4'h0;
      gnd_core_balance <= 1'b0;
      tgt_a <= 12'h000;
      {tgt_k, tgt_r} <= 24'h000000;
      // pickup bands: at pickup no flash, one above flashes
      for (i = 0; i < 4; i = i + 1) begin
         g = i % 2;
         hb = $urandom % 2;
         c = 1 + $urandom % 15;
         ph_pickup_code <= g ? 4'h0 : c[3:0];
         gnd_pickup_code <= g ? c[3:0] : 4'h0;
         ph_curve_code <= {3'h0, hb[0]};
         gnd_curve_code <= {3'h0, hb[0]};
         for (k = 0; k < 2; k = k + 1) begin
            n = pick(g, hb, c) + k;
            tgt_b <= g ? 12'h000 : n[11:0];
            tgt_r <= g ? n[11:0] : 12'h000;
            tk(6);
            seen = 1'b0;
            repeat (1004) begin
               @(negedge ref_clk);
               seen = seen | (g ? gnd_pickup_flash_ff : ph_pickup_flash_ff);
            end
            chk("flash", seen, k);
            @(posedge ref_clk);
         end
      end
      // timed trips: shape, bucket, multiplier, shift
      for (i = 0; i < 4; i = i + 1) begin
         g = i % 2;
         s = i == 3 ? 4 : $urandom % 5;
         k = i == 3 ? 3 : $urandom % 4;
         m = 1 + $urandom % 2;
         sh = i == 3 ? 1 : $urandom % 2 * 2;
         c = 1 + $urandom % 9;
         hb = $urandom % 2;
         p = pick(g, hb, c) * (1 << k) + 1;
         d = BASE[8 * (s * 4 + k) +: 8] * 50 * m;
         d = sh == 1 ? d * 2 : sh == 2 ? d / 2 : d;
         {tgt_b, tgt_r} <= 24'h000000;
         ph_pickup_code <= g ? 4'h0 : c[3:0];
         gnd_pickup_code <= g ? c[3:0] : 4'h0;
         {ph_curve_code, gnd_curve_code} <= {2{s[2:0], hb[0]}};
         {ph_mult, gnd_mult} <= {2{m[3:0]}};
         {ph_shift, gnd_shift} <= {2{sh[1:0]}};
         tk(8);
         tgt_b <= g ? 12'h000 : p[11:0];
         tgt_r <= g ? p[11:0] : 12'h000;
         n = 0;
         @(negedge ref_clk);
         while (n < 2 * d + 20 && (g ? gnd_toc_trip_ff : ph_toc_trip_ff[1]) !== 1'b1) begin
            @(negedge ref_clk);
            n = n + 1;
         end
         chk("delay", n >= 2 * d - 2 && n <= 2 * d + 8, 1);
         chk("toc", {ph_toc_trip_ff, gnd_toc_trip_ff}, g ? 1 : 4);
         chk("trip", trip_ff, 1);
         @(posedge ref_clk);
         {tgt_b, tgt_r} <= 24'h000000;
         tk(6);
         @(negedge ref_clk);
         chk("clear", {ph_toc_trip_ff, gnd_toc_trip_ff, trip_ff}, 0);
         @(posedge ref_clk);
      end
      end_sim;
   end
endmodule
